/* include/seq_pkg.sv */
// startup and fault sequencer constants, apb map, state and carrier types
// assumes a single 200 MHz pclk domain; switching rate is a divided tick
package seq_pkg;

  // clock and switching rate
  localparam int SYS_CLK_MHZ      = 200;
  localparam int SW_FREQ_KHZ      = 700;
  localparam int SW_DIV_DEF       = (SYS_CLK_MHZ * 1000) / SW_FREQ_KHZ;

  // sequencing counts, in switching ticks
  localparam int EN_DELAY_TICKS   = 384;
  localparam int SS_TICKS         = 2560;
  localparam int HICCUP_INTERVALS = 3;
  localparam int HICCUP_TICKS     = HICCUP_INTERVALS * SS_TICKS;
  localparam int PG_FILTER_TICKS  = 3;
  localparam int OC_FILTER_TICKS  = 7;
  localparam int SYNC_LOSS_TICKS  = 13;

  // gate timing, in ns and derived pclk cycles
  localparam int DEAD_TIME_NS     = 350;
  localparam int DEAD_CYC         = (DEAD_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int GATE_OFF_NS      = 100;
  localparam int GATE_OFF_CYC     = (GATE_OFF_NS * SYS_CLK_MHZ) / 1000;

  // apb map (byte addresses)
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_SSLEVEL = 8'h08;
  localparam logic [7:0]  ADDR_EVENTS  = 8'h0c;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

  // ctrl bit
  localparam int CTRL_RUN_EN = 0;

  // status bits
  localparam int ST_STATE_LSB = 0;
  localparam int ST_POWER_OK  = 3;
  localparam int ST_CLAMP     = 4;
  localparam int ST_OT        = 5;
  localparam int ST_OC_PULL   = 6;
  localparam int ST_SYNC_LOST = 7;
  localparam int ST_GATES_ON  = 8;
  localparam int ST_EN_PULL   = 9;
  localparam int ST_SINK_ON   = 10;

  // sticky event bits
  localparam int EV_OC   = 0;
  localparam int EV_OV   = 1;
  localparam int EV_OT   = 2;
  localparam int EV_LOCK = 3;
  localparam int EV_UV   = 4;
  localparam int EV_W    = 5;

  typedef enum logic [2:0] {
    st_off,
    st_delay,
    st_soft,
    st_run,
    st_hiccup,
    st_ov_latch
  } seq_state_e;

  // comparator results from the analog front end
  typedef struct packed {
    logic en_high;     // enable line above 0.8 V
    logic ov120;       // output above 120 % of target
    logic ov113;       // output above 113 % of target
    logic below87;     // output below 87 % of target
    logic pg_window;   // output inside power-good window
    logic uv;          // output below -13 % of target
    logic oc_phase;    // per-phase current comparator
    logic share_over;  // share bus above 1.2 V
    logic ot_hot;      // junction above 150 C
    logic ot_cool;     // junction below 125 C
  } sense_s;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } gate_s;

endpackage : seq_pkg

/* logic/converter_startup_fault_sequencer.sv */
// start-up, soft-start, protection and enable-line handshake sequencer
// assumes all inputs synchronous to pclk; analog comparators supplied in sense
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module converter_startup_fault_sequencer
  import seq_pkg::*;
#(
  parameter int SW_DIV     = SW_DIV_DEF,
  parameter int DELAY_LEN  = EN_DELAY_TICKS,
  parameter int SS_LEN     = SS_TICKS,
  parameter int HICCUP_LEN = HICCUP_TICKS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // supplies and frequency lock
  input  wire logic        bias_ok,
  input  wire logic        pll_locked,
  input  wire logic        sync_clock_input,
  // shared enable line (open drain, only pulls low)
  output logic             en_line_out,
  output logic             en_line_oe,
  output logic             en_sink_on,
  // comparators and modulator
  input  wire sense_s      sense,
  input  wire logic        pwm_level,
  input  wire logic        pwm_pulse,
  // gate drives and indications
  output gate_s            gates,
  output logic             power_ok_out,
  output logic [11:0]      ss_ref_out
);

  localparam logic [15:0] DIV_LAST    = 16'(SW_DIV - 1);
  localparam logic [15:0] DELAY_LAST  = 16'(DELAY_LEN - 1);
  localparam logic [15:0] SS_LAST     = 16'(SS_LEN - 1);
  localparam logic [15:0] HICCUP_LAST = 16'(HICCUP_LEN - 1);
  localparam logic [11:0] SS_FULL     = 12'(SS_LEN);
  localparam logic [3:0]  SYNC_LIM    = 4'(SYNC_LOSS_TICKS);
  localparam logic [2:0]  OC_LIM      = 3'(OC_FILTER_TICKS);
  localparam logic [1:0]  PG_LIM      = 2'(PG_FILTER_TICKS);
  localparam logic [6:0]  DEAD_LOAD   = 7'(DEAD_CYC);

  // registers
  seq_state_e      state_reg, state_next;
  logic [15:0]     div_reg;
  logic            tick_reg;
  logic [15:0]     cnt_reg, cnt_next;
  logic [11:0]     ss_reg;
  sense_s          sense_q;
  logic            sync_d_reg;
  logic [3:0]      sync_miss_reg;
  logic [2:0]      oc_cnt_reg;
  logic [1:0]      bad_cnt_reg;
  logic            oc_pull_reg, oc_pull_next;
  logic            ot_reg;
  logic            clamp_reg;
  logic            ls_done_reg;
  logic            gates_open_reg;
  logic            hs_reg, ls_reg;
  logic [6:0]      dead_reg;
  logic [31:0]     ctrl_reg;
  logic [EV_W-1:0] events_reg;

  // decode
  wire sync_edge   = sync_clock_input & ~sync_d_reg;
  wire sync_lost   = (sync_miss_reg == SYNC_LIM);
  wire lock_ok     = pll_locked & ~sync_lost;
  wire run_en      = ctrl_reg[CTRL_RUN_EN];
  wire active      = (state_reg == st_soft) || (state_reg == st_run);
  wire oc_declared = active & ((oc_cnt_reg == OC_LIM) | sense_q.share_over);
  wire start_ok    = bias_ok & lock_ok & run_en & ~ot_reg & sense_q.en_high;
  // our own oc pull also lowers the line; do not treat that as a remote disable
  wire line_drop   = ~sense_q.en_high & ~oc_pull_reg;
  wire keep_on     = bias_ok & lock_ok & run_en & ~ot_reg & ~line_drop;
  wire other_fault = oc_pull_reg | ot_reg | ~lock_ok | (state_reg == st_ov_latch);
  wire uv_armed    = (state_reg == st_run) & sense_q.uv & ~other_fault;
  wire pg_bad      = ~sense_q.pg_window | uv_armed;
  wire en_pull     = ot_reg | oc_pull_reg | (state_reg == st_ov_latch);

  // gate demands
  wire want_hs = gates_open_reg & active & pwm_level & ~clamp_reg & ~en_pull;
  wire want_ls = (state_reg == st_ov_latch) ? ~ls_done_reg :
                 clamp_reg ? 1'b1 :
                 (gates_open_reg & active & ~pwm_level & ~en_pull);
  wire hs_next = bias_ok & want_hs & ~ls_reg & (dead_reg == 7'h00);
  wire ls_next = bias_ok & want_ls & ~hs_reg & (dead_reg == 7'h00);
  wire turn_off = (hs_reg & ~hs_next) | (ls_reg & ~ls_next);

  // apb decode
  wire apb_setup  = psel & ~penable;
  wire apb_write  = psel & penable & pwrite;
  wire hit_ctrl   = (paddr == ADDR_CTRL);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_ss     = (paddr == ADDR_SSLEVEL);
  wire hit_events = (paddr == ADDR_EVENTS);
  wire hit_any    = hit_ctrl | hit_status | hit_ss | hit_events;

  wire [31:0] status_word = {21'h0, en_sink_on, en_line_oe, gates_open_reg,
                             sync_lost, oc_pull_reg, ot_reg, clamp_reg,
                             power_ok_out, state_reg};
  wire [31:0] rd_word = hit_ctrl   ? ctrl_reg :
                        hit_status ? status_word :
                        hit_ss     ? {20'h0, ss_reg} :
                        hit_events ? {{(32 - EV_W){1'b0}}, events_reg} :
                        32'h0;

  wire [EV_W-1:0] ev_set = {uv_armed & tick_reg & (bad_cnt_reg == PG_LIM),
                            lock_ok ? 1'b0 : pll_locked,
                            sense_q.ot_hot & tick_reg,
                            (state_next == st_ov_latch) & (state_reg != st_ov_latch),
                            oc_declared & tick_reg};
  wire [EV_W-1:0] ev_clr = (apb_write & hit_events) ? pwdata[EV_W-1:0] : {EV_W{1'b0}};

  // sequencer
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    oc_pull_next = oc_pull_reg;
    if (!bias_ok) begin
      // supply loss clears state, count and oc pull, latch included
      state_next   = st_off;
      cnt_next     = 16'h0;
      oc_pull_next = 1'b0;
    end else if (tick_reg) begin
      case (state_reg)
        st_off: begin
          cnt_next = 16'h0;
          if (start_ok) begin
            state_next = st_delay;
          end
        end
        st_delay: begin
          cnt_next = cnt_reg + 16'h1;
          if (sense_q.ov120) begin
            state_next = st_ov_latch;
          end else if (!start_ok) begin
            state_next = st_off;
          end else if (cnt_reg == DELAY_LAST) begin
            state_next = st_soft;
            cnt_next   = 16'h0;
          end
        end
        st_soft: begin
          cnt_next = cnt_reg + 16'h1;
          if (oc_declared) begin
            oc_pull_next = 1'b1;
          end
          if (sense_q.ov120) begin
            state_next = st_ov_latch;
          end else if (!keep_on) begin
            state_next   = st_off;
            oc_pull_next = 1'b0;
          end else if (cnt_reg == SS_LAST) begin
            cnt_next   = 16'h0;
            state_next = (oc_pull_reg || oc_declared) ? st_hiccup : st_run;
          end
        end
        st_run: begin
          cnt_next = 16'h0;
          if (sense_q.ov120) begin
            state_next = st_ov_latch;
          end else if (oc_declared) begin
            state_next   = st_hiccup;
            oc_pull_next = 1'b1;
          end else if (!keep_on) begin
            state_next = st_off;
          end
        end
        st_hiccup: begin
          cnt_next     = cnt_reg + 16'h1;
          oc_pull_next = 1'b1;
          if (sense_q.ov120) begin
            state_next = st_ov_latch;
          end else if (!lock_ok || !run_en || ot_reg) begin
            state_next   = st_off;
            oc_pull_next = 1'b0;
          end else if (cnt_reg == HICCUP_LAST) begin
            state_next   = st_soft;
            cnt_next     = 16'h0;
            oc_pull_next = 1'b0;
          end
        end
        st_ov_latch: begin
          cnt_next     = 16'h0;
          oc_pull_next = 1'b0;
        end
        default: begin
          state_next = st_off;
          cnt_next   = 16'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= st_off;
      cnt_reg     <= 16'h0;
      oc_pull_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      oc_pull_reg <= oc_pull_next;
    end
  end

  // switching tick divider and once-per-tick comparator sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 16'h0;
      tick_reg <= 1'b0;
      sense_q  <= '0;
    end else begin
      div_reg  <= (div_reg == DIV_LAST) ? 16'h0 : div_reg + 16'h1;
      tick_reg <= (div_reg == DIV_LAST);
      if (div_reg == DIV_LAST) begin
        sense_q <= sense;
      end
    end
  end

  // sync watchdog, counted in ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d_reg    <= 1'b0;
      sync_miss_reg <= 4'h0;
    end else begin
      sync_d_reg <= sync_clock_input;
      if (sync_edge) begin
        sync_miss_reg <= 4'h0;
      end else if (tick_reg && !sync_lost) begin
        sync_miss_reg <= sync_miss_reg + 4'h1;
      end
    end
  end

  // soft-start level: cleared at once when not ramping or running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_reg <= 12'h0;
    end else if (!active || state_next == st_off || state_next == st_ov_latch) begin
      ss_reg <= 12'h0;
    end else if (state_reg == st_run) begin
      ss_reg <= SS_FULL;
    end else if (tick_reg && ss_reg != SS_FULL) begin
      ss_reg <= ss_reg + 12'h1;
    end
  end

  // fault filters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_reg  <= 3'h0;
      bad_cnt_reg <= 2'h0;
      ot_reg      <= 1'b0;
      clamp_reg   <= 1'b0;
      ls_done_reg <= 1'b0;
    end else if (tick_reg) begin
      if (!active || !sense_q.oc_phase) begin
        oc_cnt_reg <= 3'h0;
      end else if (oc_cnt_reg != OC_LIM) begin
        oc_cnt_reg <= oc_cnt_reg + 3'h1;
      end
      if (!pg_bad) begin
        bad_cnt_reg <= 2'h0;
      end else if (bad_cnt_reg != PG_LIM) begin
        bad_cnt_reg <= bad_cnt_reg + 2'h1;
      end
      if (sense_q.ot_hot) begin
        ot_reg <= 1'b1;
      end else if (sense_q.ot_cool) begin
        ot_reg <= 1'b0;
      end
      // non-latching clamp shares the sink current among paralleled modules
      if (!sense_q.en_high && sense_q.ov113 && state_reg != st_ov_latch) begin
        clamp_reg <= 1'b1;
      end else if (sense_q.below87 || state_reg == st_ov_latch) begin
        clamp_reg <= 1'b0;
      end
      if (state_reg != st_ov_latch) begin
        ls_done_reg <= 1'b0;
      end else if (sense_q.below87) begin
        ls_done_reg <= 1'b1;
      end
    end
  end

  // prebias gate connect: no pwm demand reaches the drivers before the first pulse; clamp and ov latch drive the low side regardless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates_open_reg <= 1'b0;
    end else if (!active || oc_pull_reg || !bias_ok) begin
      gates_open_reg <= 1'b0;
    end else if (pwm_pulse) begin
      gates_open_reg <= 1'b1;
    end
  end

  // gate drivers with dead time; turning off is never delayed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_reg   <= 1'b0;
      ls_reg   <= 1'b0;
      dead_reg <= 7'h0;
    end else begin
      hs_reg <= hs_next;
      ls_reg <= ls_next;
      if (turn_off) begin
        dead_reg <= DEAD_LOAD;
      end else if (dead_reg != 7'h00) begin
        dead_reg <= dead_reg - 7'h1;
      end
    end
  end

  // pins and indications
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates        <= '0;
      en_line_out  <= 1'b0;
      en_line_oe   <= 1'b0;
      en_sink_on   <= 1'b1;
      power_ok_out <= 1'b0;
      ss_ref_out   <= 12'h0;
    end else begin
      gates.high_side_drive <= hs_next;
      gates.low_side_drive  <= ls_next;
      en_line_out  <= 1'b0;
      en_line_oe   <= en_pull;
      en_sink_on   <= (state_reg == st_off) || (state_reg == st_ov_latch);
      power_ok_out <= (state_reg == st_run) && keep_on &&
                      (bad_cnt_reg != PG_LIM);
      ss_ref_out   <= ss_reg;
    end
  end

  // apb slave: one wait-free access phase, answer registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      prdata     <= 32'h0;
      pslverr    <= 1'b0;
      ctrl_reg   <= CTRL_RESET;
      events_reg <= '0;
    end else begin
      pready  <= apb_setup;
      prdata  <= (apb_setup && !pwrite) ? rd_word : 32'h0;
      pslverr <= apb_setup && !hit_any;
      if (apb_write && hit_ctrl) begin
        ctrl_reg <= {31'h0, pwdata[CTRL_RUN_EN]};
      end
      // a new event in the clearing cycle survives
      events_reg <= (events_reg & ~ev_clr) | ev_set;
    end
  end

endmodule : converter_startup_fault_sequencer

/* verif/converter_startup_fault_sequencer_test.sv */
// bench for the sequencer with a neighbour module on the enable line
// assumes seq_pkg compiled first; long counts shortened by parameter
module converter_startup_fault_sequencer_test import seq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 4;
  localparam int DLY = 4;
  localparam int SSL = 8;
  localparam int HCL = 24;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        bias_ok, ext_en, fault_req, pull_low;
  logic        sync_in = 1'b0, pwm_level = 1'b0, pwm_pulse = 1'b0;
  logic        running, line_level, en_line_out, en_line_oe, en_sink_on, power_ok_out;
  logic [11:0] ss_ref_out;
  sense_s      sns, sense_w;
  gate_s       gates;
  int          fail_count = 0, n_tests = 0, n, m;

  always #2.5 pclk = ~pclk;
  // wired line: external pull-up gated by every pull-down
  assign line_level = ext_en && !en_line_oe && !pull_low;
  assign sense_w    = {line_level, sns[8:0]};
  always @(posedge pclk) begin
    pwm_level <= 1'($urandom);
    pwm_pulse <= 1'($urandom);
    sync_in   <= ~sync_in;
  end

  converter_startup_fault_sequencer #(.SW_DIV(DIV), .DELAY_LEN(DLY), .SS_LEN(SSL),
    .HICCUP_LEN(HCL)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bias_ok(bias_ok), .pll_locked(1'b1), .sync_clock_input(sync_in),
    .en_line_out(en_line_out), .en_line_oe(en_line_oe), .en_sink_on(en_sink_on),
    .sense(sense_w), .pwm_level(pwm_level), .pwm_pulse(pwm_pulse), .gates(gates),
    .power_ok_out(power_ok_out), .ss_ref_out(ss_ref_out));
  neighbour_module nb (.pclk(pclk), .presetn(presetn), .fault_req(fault_req),
    .line_level(line_level), .pull_low(pull_low), .running(running));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic ticks(input int k);
    repeat (k * DIV) @(posedge pclk);
  endtask : ticks

  // sel 0 watches power ok, 1 the line pull
  task automatic wait_until(input int sel, input logic v, output int cnt);
    for (cnt = 0; cnt < 2000; cnt++) begin
      @(posedge pclk);
      if ((sel ? en_line_oe : power_ok_out) === v) return;
    end
    check("timeout", 0, 1);
    close_out();
  endtask : wait_until

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      check("apb_wait", 0, 1);
      close_out();
    end
  endtask : apb

  initial begin
    void'($urandom(25966));
    {presetn, psel, penable, pwrite, ext_en, fault_req} = '0;
    paddr = '0;
    pwdata = '0;
    bias_ok = 1'b1;
    sns = '0;
    sns.pg_window = 1'b1;
    sns.ot_cool = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_CTRL, '0);
    check("ctrl", rd, CTRL_RESET);
    apb(0, ADDR_STATUS, '0);
    check("sink", rd[ST_SINK_ON], 1);
    check("sink_pin", en_sink_on, 1);
    apb(0, 8'h10, '0);
    check("unmapped", rd, 0);
    check("slverr", err, 1);
    check("line_out", en_line_out, 0);
    ext_en <= 1'b1;
    wait_until(0, 1'b1, n);
    check("start", n >= (DLY + SSL) * DIV && n <= (DLY + SSL + 3) * DIV, 1);
    check("ss_full", ss_ref_out, SSL);
    apb(0, ADDR_STATUS, '0);
    check("run", rd[2:0], 3);
    check("sink_off", rd[ST_SINK_ON], 0);
    sns.pg_window <= 1'b0;
    ticks(2);
    sns.pg_window <= 1'b1;
    ticks(1);
    check("pg_hold", power_ok_out, 1);
    sns.pg_window <= 1'b0;
    ticks(5);
    check("pg_drop", power_ok_out, 0);
    sns.pg_window <= 1'b1;
    sns.oc_phase <= 1'b1;
    wait_until(1, 1'b1, n);
    check("oc_filter", n >= 7 * DIV, 1);
    sns.oc_phase <= 1'b0;
    wait_until(1, 1'b0, n);
    check("hiccup", n >= (HCL - 1) * DIV && n <= (HCL + 2) * DIV, 1);
    sns.oc_phase <= 1'b1;
    wait_until(1, 1'b1, m);
    sns.oc_phase <= 1'b0;
    check("retry_pg", power_ok_out, 0);
    wait_until(1, 1'b0, n);
    check("retry", m + n >= (SSL + HCL - 1) * DIV && m + n <= (SSL + HCL + 3) * DIV, 1);
    wait_until(0, 1'b1, n);
    check("pg_back", n <= (SSL + 3) * DIV, 1);
    sns.uv <= 1'b1;
    ticks(5);
    check("uv_pg", power_ok_out, 0);
    sns.uv <= 1'b0;
    apb(0, ADDR_EVENTS, '0);
    check("ev_oc", rd[EV_OC], 1);
    check("ev_uv", rd[EV_UV], 1);
    apb(1, ADDR_EVENTS, $urandom | 32'h1f);
    apb(0, ADDR_EVENTS, '0);
    check("ev_clear", rd[4:0], 0);
    fault_req <= 1'b1;
    ticks(4);
    check("remote_pg", power_ok_out, 0);
    check("nb_stop", running, 0);
    // line held low by the neighbour: the non-latching clamp must act
    sns.ov113 <= 1'b1;
    ticks(20);
    check("clamp_on", gates.low_side_drive, 1);
    sns.ov113 <= 1'b0;
    sns.below87 <= 1'b1;
    ticks(2);
    check("clamp_off", gates.low_side_drive, 0);
    sns.below87 <= 1'b0;
    fault_req <= 1'b0;
    wait_until(0, 1'b1, n);
    check("restart", n >= (DLY + SSL) * DIV, 1);
    sns.ot_hot <= 1'b1;
    sns.ot_cool <= 1'b0;
    wait_until(1, 1'b1, n);
    sns.ot_hot <= 1'b0;
    ticks(4);
    check("ot_hold", en_line_oe, 1);
    sns.ot_cool <= 1'b1;
    wait_until(1, 1'b0, n);
    wait_until(0, 1'b1, n);
    sns.ov120 <= 1'b1;
    wait_until(1, 1'b1, n);
    ticks(20);
    check("ov_hs", gates.high_side_drive, 0);
    check("ov_ls_on", gates.low_side_drive, 1);
    sns.ov120 <= 1'b0;
    sns.below87 <= 1'b1;
    ticks(4);
    check("ov_ls_off", gates.low_side_drive, 0);
    apb(0, ADDR_STATUS, '0);
    check("ov_latch", rd[2:0], 5);
    check("ov_hold", {power_ok_out, en_line_oe}, 2'b01);
    bias_ok <= 1'b0;
    sns.below87 <= 1'b0;
    ticks(2);
    bias_ok <= 1'b1;
    apb(0, ADDR_STATUS, '0);
    check("unlatch", rd[2:0] == 3'd5, 0);
    close_out();
  end
endmodule : converter_startup_fault_sequencer_test

bind converter_startup_fault_sequencer sequencer_props #(.SS_LEN(SS_LEN)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .bias_ok(bias_ok), .en_line_oe(en_line_oe), .en_sink_on(en_sink_on),
  .gates(gates), .power_ok_out(power_ok_out), .ss_ref_out(ss_ref_out));

/* verif/neighbour_module.sv */
// neighbour module on the shared open-drain enable line
// assumes the bench resolves the line level from all pull-downs
module neighbour_module (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // fault and line
  input  wire logic fault_req,
  input  wire logic line_level,
  output logic      pull_low,
  output logic      running
);
  timeunit 1ns;
  timeprecision 100ps;
  // a local fault pulls the line; a low line stops this neighbour too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_low <= 1'b0;
      running  <= 1'b0;
    end else begin
      pull_low <= fault_req;
      running  <= line_level;
    end
  end
endmodule : neighbour_module

/* verif/sequencer_properties.sv */
// port relations of the start-up and fault sequencer over time
// assumes a bind from the bench top and a single pclk domain
module sequencer_props
  import seq_pkg::*;
#(
  parameter int SS_LEN = SS_TICKS
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // watched
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bias_ok,
  input wire logic        en_line_oe,
  input wire logic        en_sink_on,
  input wire gate_s       gates,
  input wire logic        power_ok_out,
  input wire logic [11:0] ss_ref_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  int dead_cnt;
  // starts full so the first turn-on after reset is not flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dead_cnt <= DEAD_CYC;
    else if ($fell(gates.high_side_drive) || $fell(gates.low_side_drive)) dead_cnt <= 0;
    else if (dead_cnt < DEAD_CYC) dead_cnt <= dead_cnt + 1;
  end

  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ss_ceiling: assert property (ss_ref_out <= 12'(SS_LEN))
    else $error("soft-start above full ramp");
  a_ss_step: assert property (ss_ref_out > $past(ss_ref_out) |->
    ss_ref_out == $past(ss_ref_out) + 12'h001) else $error("soft-start jumped");
  a_ss_pace: assert property (ss_ref_out == $past(ss_ref_out) + 12'h001 |=>
    (ss_ref_out == $past(ss_ref_out) || ss_ref_out == 12'h000) [*3])
    else $error("soft-start faster than tick");
  a_pg_ramp_done: assert property ($rose(power_ok_out) |->
    ss_ref_out == 12'(SS_LEN) && !en_sink_on) else $error("power ok before ramp end");
  a_bias_gates: assert property (!bias_ok |=> gates == 2'b00)
    else $error("gates on after supply loss");
  a_pull_hs_off: assert property ($rose(en_line_oe) |-> ##1 !gates.high_side_drive [*2])
    else $error("high side on while pulling line");
  a_gate_excl: assert property (!(gates.high_side_drive && gates.low_side_drive))
    else $error("both gates on");
  a_dead_time: assert property ($rose(gates.high_side_drive) ||
    $rose(gates.low_side_drive) |-> dead_cnt >= DEAD_CYC - 1) else $error("dead time short");

  c_pg_up: cover property ($rose(power_ok_out));
  c_pull: cover property ($rose(en_line_oe));
  c_err: cover property (pslverr);
endmodule : sequencer_props
